// ### src/pbc_apb_slave.sv
// Purpose: APB slave front end, zero wait states
// Assumes: master holds the request steady through the access phase
// Notes:   read data and error are captured in setup, shown in access
`timescale 1ns/1ps
`default_nettype none
module pbc_apb_slave (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// apb
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic             pready_out,
	output logic [31:0]      prdata_out,
	output logic             pslverr_out,
	// register side
	pbc_reg_if.slave         regs
);
	logic setup;

	// setup phase is where decode and read data are sampled
	assign setup        = psel_in && !penable_in;
	assign regs.rd_req  = setup && !pwrite_in;
	assign regs.wr_req  = psel_in && penable_in && pwrite_in && regs.hit;
	assign regs.addr    = paddr_in;
	assign regs.wdata   = pwdata_in;
	assign regs.strb    = pstrb_in;
	// every access phase completes at once
	assign pready_out   = 1'b1;

	// registering read data keeps prdata glitch free in the access phase
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prdata_out <= pbc_pkg::DATA_ZERO;
		end else if (regs.rd_req) begin
			prdata_out <= regs.hit ? regs.rdata : pbc_pkg::DATA_ZERO;
		end
	end

	// unmapped addresses answer with an error, writes to them are dropped
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pslverr_out <= 1'b0;
		end else if (setup) begin
			pslverr_out <= !regs.hit;
		end
	end
endmodule
`default_nettype wire

// ### src/pbc_pkg.sv
// Purpose: constants for the port 1 transceiver basic control register bank
// Assumes: 32-bit APB data, 16-bit registers in the low half of each word
// Notes:   byte addresses below are word aligned
package pbc_pkg;
	localparam int          ADDR_W         = 12;
	localparam int          REG_W          = 16;
	// register byte addresses
	localparam logic [11:0] ADDR_BASIC     = 12'h04c;
	localparam logic [11:0] ADDR_CTRL4     = 12'h100;
	localparam logic [11:0] ADDR_LSTAT     = 12'h104;
	// basic control field positions
	localparam int          BC_LOOPBACK    = 14;
	localparam int          BC_FORCE100    = 13;
	localparam int          BC_AN_EN       = 12;
	localparam int          BC_PDOWN       = 11;
	localparam int          BC_ISOLATE     = 10;
	localparam int          BC_AN_RESTART  = 9;
	localparam int          BC_FULL_DUP    = 8;
	localparam int          BC_COL_TEST    = 7;
	localparam int          BC_RSVD6       = 6;
	localparam int          BC_XOVER_ALG   = 5;
	localparam int          BC_FORCE_MDIX  = 4;
	localparam int          BC_MDIX_DIS    = 3;
	localparam int          BC_RSVD2       = 2;
	localparam int          BC_TX_DIS      = 1;
	localparam int          BC_RSVD0       = 0;
	localparam int          BC_RSVD15      = 15;
	// control four field positions that alias the basic register
	localparam int          C4_LOOPBACK    = 8;
	localparam int          C4_FORCE100    = 6;
	localparam int          C4_AN_EN       = 7;
	localparam int          C4_PDOWN       = 11;
	localparam int          C4_AN_RESTART  = 13;
	localparam int          C4_FULL_DUP    = 5;
	localparam int          C4_FORCE_MDIX  = 9;
	localparam int          C4_MDIX_DIS    = 10;
	localparam int          C4_RSVD        = 12;
	localparam int          C4_TX_DIS      = 14;
	// link status field positions
	localparam int          LS_XOVER_ALG   = 15;
	localparam int          LS_AN_DONE     = 6;
	localparam int          LS_LINK_UP     = 5;
	// reset values of stored bits
	localparam logic        RST_LOOPBACK   = 1'b0;
	localparam logic        RST_FORCE100   = 1'b1;
	localparam logic        RST_AN_EN      = 1'b1;
	localparam logic        RST_PDOWN      = 1'b0;
	localparam logic        RST_FULL_DUP   = 1'b1;
	localparam logic        RST_XOVER_ALG  = 1'b1;
	localparam logic        RST_FORCE_MDIX = 1'b0;
	localparam logic        RST_MDIX_DIS   = 1'b0;
	localparam logic        RST_RSVD       = 1'b0;
	localparam logic        RST_TX_DIS     = 1'b0;
	localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;
endpackage

// ### src/pbc_reg_if.sv
// Purpose: carrier between the APB slave and the register bank
// Assumes: one clock domain
// Notes:   rd_req is the setup phase of a read, wr_req the access phase
`timescale 1ns/1ps
`default_nettype none
interface pbc_reg_if;
	logic        rd_req;
	logic        wr_req;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic [3:0]  strb;
	logic [31:0] rdata;
	logic        hit;
	modport slave (output rd_req, output wr_req, output addr, output wdata,
		output strb, input rdata, input hit);
	modport regs (input rd_req, input wr_req, input addr, input wdata,
		input strb, output rdata, output hit);
endinterface
`default_nettype wire

// ### src/pbc_restart_flag.sv
// Purpose: self-clearing negotiation restart request
// Assumes: the transceiver acknowledges with a one-cycle pulse
// Notes:   a new request in the acknowledge cycle survives
`timescale 1ns/1ps
`default_nettype none
module pbc_restart_flag (
	// clock and reset
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	// request and acknowledge
	input  wire logic set_in,
	input  wire logic ack_in,
	output logic      pending_out
);
	// set wins over the acknowledge so no restart is lost
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pending_out <= 1'b0;
		end else if (set_in) begin
			pending_out <= 1'b1;
		end else if (ack_in) begin
			pending_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### src/pbc_top.sv
// Purpose: port 1 transceiver basic control register bank on APB
// Assumes: transceiver status arrives from another clock domain
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pbc_top (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// apb
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [3:0]  pstrb_in,
	output logic             pready_out,
	output logic [31:0]      prdata_out,
	output logic             pslverr_out,
	// transceiver status
	input  wire logic        link_up_in,
	input  wire logic        an_done_in,
	input  wire logic        an_restart_ack_in,
	// transceiver controls
	output logic             far_end_loopback_out,
	output logic             force_100_out,
	output logic             an_enable_out,
	output logic             power_down_out,
	output logic             an_restart_out,
	output logic             force_full_duplex_out,
	output logic             crossover_algorithm_select_out,
	output logic             force_mdix_out,
	output logic             auto_mdix_disable_out,
	output logic             tx_disable_out
);
	pbc_reg_if regs ();

	logic        rsvd2;
	logic        rsvd0;
	logic        link_up_meta;
	logic        link_up_sync;
	logic        an_done_meta;
	logic        an_done_sync;
	logic        hit_basic;
	logic        hit_ctrl4;
	logic        hit_lstat;
	logic [15:0] wm_basic;
	logic [15:0] wm_ctrl4;
	logic [15:0] wm_lstat;
	logic [15:0] view_basic;
	logic [15:0] view_ctrl4;
	logic [15:0] view_lstat;
	logic        restart_set;

	// byte enables of the low half into a per-bit write mask
	function automatic logic [15:0] lane_mask(input logic hit,
		input logic [3:0] strb);
		lane_mask = {{8{hit && strb[1]}}, {8{hit && strb[0]}}};
	endfunction

	// next value of a shared flop written through either of two places
	function automatic logic merge(input logic cur,
		input logic m_a, input logic d_a, input logic m_b, input logic d_b);
		if (m_a) begin
			merge = d_a;
		end else if (m_b) begin
			merge = d_b;
		end else begin
			merge = cur;
		end
	endfunction

	pbc_apb_slave u_apb (
		.clk_sys_in  (clk_sys_in),
		.reset_n_in  (reset_n_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.pwrite_in   (pwrite_in),
		.paddr_in    (paddr_in),
		.pwdata_in   (pwdata_in),
		.pstrb_in    (pstrb_in),
		.pready_out  (pready_out),
		.prdata_out  (prdata_out),
		.pslverr_out (pslverr_out),
		.regs        (regs.slave)
	);

	// address decode
	assign hit_basic = regs.addr == pbc_pkg::ADDR_BASIC;
	assign hit_ctrl4 = regs.addr == pbc_pkg::ADDR_CTRL4;
	assign hit_lstat = regs.addr == pbc_pkg::ADDR_LSTAT;
	assign regs.hit  = hit_basic || hit_ctrl4 || hit_lstat;
	assign wm_basic  = lane_mask(regs.wr_req && hit_basic, regs.strb);
	assign wm_ctrl4  = lane_mask(regs.wr_req && hit_ctrl4, regs.strb);
	assign wm_lstat  = lane_mask(regs.wr_req && hit_lstat, regs.strb);

	// status comes from the transceiver clock, so two flops first
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link_up_meta <= 1'b0;
			link_up_sync <= 1'b0;
			an_done_meta <= 1'b0;
			an_done_sync <= 1'b0;
		end else begin
			link_up_meta <= link_up_in;
			link_up_sync <= link_up_meta;
			an_done_meta <= an_done_in;
			an_done_sync <= an_done_meta;
		end
	end

	// loopback, speed, negotiation enable and power-down share one flop each
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			far_end_loopback_out <= pbc_pkg::RST_LOOPBACK;
			force_100_out        <= pbc_pkg::RST_FORCE100;
			an_enable_out        <= pbc_pkg::RST_AN_EN;
			power_down_out       <= pbc_pkg::RST_PDOWN;
		end else begin
			far_end_loopback_out <= merge(far_end_loopback_out,
				wm_basic[pbc_pkg::BC_LOOPBACK],
				regs.wdata[pbc_pkg::BC_LOOPBACK],
				wm_ctrl4[pbc_pkg::C4_LOOPBACK],
				regs.wdata[pbc_pkg::C4_LOOPBACK]);
			force_100_out <= merge(force_100_out,
				wm_basic[pbc_pkg::BC_FORCE100],
				regs.wdata[pbc_pkg::BC_FORCE100],
				wm_ctrl4[pbc_pkg::C4_FORCE100],
				regs.wdata[pbc_pkg::C4_FORCE100]);
			an_enable_out <= merge(an_enable_out,
				wm_basic[pbc_pkg::BC_AN_EN],
				regs.wdata[pbc_pkg::BC_AN_EN],
				wm_ctrl4[pbc_pkg::C4_AN_EN],
				regs.wdata[pbc_pkg::C4_AN_EN]);
			power_down_out <= merge(power_down_out,
				wm_basic[pbc_pkg::BC_PDOWN],
				regs.wdata[pbc_pkg::BC_PDOWN],
				wm_ctrl4[pbc_pkg::C4_PDOWN],
				regs.wdata[pbc_pkg::C4_PDOWN]);
		end
	end

	// duplex and crossover controls; the algorithm bit aliases link status
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			force_full_duplex_out          <= pbc_pkg::RST_FULL_DUP;
			crossover_algorithm_select_out <= pbc_pkg::RST_XOVER_ALG;
			force_mdix_out                 <= pbc_pkg::RST_FORCE_MDIX;
			auto_mdix_disable_out          <= pbc_pkg::RST_MDIX_DIS;
		end else begin
			force_full_duplex_out <= merge(force_full_duplex_out,
				wm_basic[pbc_pkg::BC_FULL_DUP],
				regs.wdata[pbc_pkg::BC_FULL_DUP],
				wm_ctrl4[pbc_pkg::C4_FULL_DUP],
				regs.wdata[pbc_pkg::C4_FULL_DUP]);
			crossover_algorithm_select_out <= merge(
				crossover_algorithm_select_out,
				wm_basic[pbc_pkg::BC_XOVER_ALG],
				regs.wdata[pbc_pkg::BC_XOVER_ALG],
				wm_lstat[pbc_pkg::LS_XOVER_ALG],
				regs.wdata[pbc_pkg::LS_XOVER_ALG]);
			force_mdix_out <= merge(force_mdix_out,
				wm_basic[pbc_pkg::BC_FORCE_MDIX],
				regs.wdata[pbc_pkg::BC_FORCE_MDIX],
				wm_ctrl4[pbc_pkg::C4_FORCE_MDIX],
				regs.wdata[pbc_pkg::C4_FORCE_MDIX]);
			auto_mdix_disable_out <= merge(auto_mdix_disable_out,
				wm_basic[pbc_pkg::BC_MDIX_DIS],
				regs.wdata[pbc_pkg::BC_MDIX_DIS],
				wm_ctrl4[pbc_pkg::C4_MDIX_DIS],
				regs.wdata[pbc_pkg::C4_MDIX_DIS]);
		end
	end

	// transmitter disable and the reserved storage bits, which steer nothing
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_disable_out <= pbc_pkg::RST_TX_DIS;
			rsvd2          <= pbc_pkg::RST_RSVD;
			rsvd0          <= pbc_pkg::RST_RSVD;
		end else begin
			tx_disable_out <= merge(tx_disable_out,
				wm_basic[pbc_pkg::BC_TX_DIS],
				regs.wdata[pbc_pkg::BC_TX_DIS],
				wm_ctrl4[pbc_pkg::C4_TX_DIS],
				regs.wdata[pbc_pkg::C4_TX_DIS]);
			rsvd2 <= merge(rsvd2, wm_basic[pbc_pkg::BC_RSVD2],
				regs.wdata[pbc_pkg::BC_RSVD2],
				wm_ctrl4[pbc_pkg::C4_RSVD], regs.wdata[pbc_pkg::C4_RSVD]);
			rsvd0 <= merge(rsvd0, wm_basic[pbc_pkg::BC_RSVD0],
				regs.wdata[pbc_pkg::BC_RSVD0], 1'b0, 1'b0);
		end
	end

	// writing zero cannot cancel a restart that the transceiver has not taken
	assign restart_set =
		(wm_basic[pbc_pkg::BC_AN_RESTART] &&
			regs.wdata[pbc_pkg::BC_AN_RESTART]) ||
		(wm_ctrl4[pbc_pkg::C4_AN_RESTART] &&
			regs.wdata[pbc_pkg::C4_AN_RESTART]);

	pbc_restart_flag u_restart (
		.clk_sys_in  (clk_sys_in),
		.reset_n_in  (reset_n_in),
		.set_in      (restart_set),
		.ack_in      (an_restart_ack_in),
		.pending_out (an_restart_out)
	);

	// read views; unsupported and reserved read-only bits stay zero
	always_comb begin
		view_basic = 16'h0000;
		view_basic[pbc_pkg::BC_LOOPBACK]   = far_end_loopback_out;
		view_basic[pbc_pkg::BC_FORCE100]   = force_100_out;
		view_basic[pbc_pkg::BC_AN_EN]      = an_enable_out;
		view_basic[pbc_pkg::BC_PDOWN]      = power_down_out;
		view_basic[pbc_pkg::BC_AN_RESTART] = an_restart_out;
		view_basic[pbc_pkg::BC_FULL_DUP]   = force_full_duplex_out;
		view_basic[pbc_pkg::BC_XOVER_ALG]  = crossover_algorithm_select_out;
		view_basic[pbc_pkg::BC_FORCE_MDIX] = force_mdix_out;
		view_basic[pbc_pkg::BC_MDIX_DIS]   = auto_mdix_disable_out;
		view_basic[pbc_pkg::BC_RSVD2]      = rsvd2;
		view_basic[pbc_pkg::BC_TX_DIS]     = tx_disable_out;
		view_basic[pbc_pkg::BC_RSVD0]      = rsvd0;
	end

	// the same flops seen through control four
	always_comb begin
		view_ctrl4 = 16'h0000;
		view_ctrl4[pbc_pkg::C4_LOOPBACK]   = far_end_loopback_out;
		view_ctrl4[pbc_pkg::C4_FORCE100]   = force_100_out;
		view_ctrl4[pbc_pkg::C4_AN_EN]      = an_enable_out;
		view_ctrl4[pbc_pkg::C4_PDOWN]      = power_down_out;
		view_ctrl4[pbc_pkg::C4_AN_RESTART] = an_restart_out;
		view_ctrl4[pbc_pkg::C4_FULL_DUP]   = force_full_duplex_out;
		view_ctrl4[pbc_pkg::C4_FORCE_MDIX] = force_mdix_out;
		view_ctrl4[pbc_pkg::C4_MDIX_DIS]   = auto_mdix_disable_out;
		view_ctrl4[pbc_pkg::C4_RSVD]       = rsvd2;
		view_ctrl4[pbc_pkg::C4_TX_DIS]     = tx_disable_out;
	end

	// link status shows live transceiver state plus the algorithm alias
	always_comb begin
		view_lstat = 16'h0000;
		view_lstat[pbc_pkg::LS_XOVER_ALG] = crossover_algorithm_select_out;
		view_lstat[pbc_pkg::LS_AN_DONE]   = an_done_sync;
		view_lstat[pbc_pkg::LS_LINK_UP]   = link_up_sync;
	end

	// read mux; upper half of the word reads zero
	always_comb begin
		if (hit_basic) begin
			regs.rdata = {16'h0000, view_basic};
		end else if (hit_ctrl4) begin
			regs.rdata = {16'h0000, view_ctrl4};
		end else if (hit_lstat) begin
			regs.rdata = {16'h0000, view_lstat};
		end else begin
			regs.rdata = pbc_pkg::DATA_ZERO;
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);

	// a full write to the basic register lands on the loopback control
	a_loopback_write: assert property (
		wm_basic[pbc_pkg::BC_LOOPBACK] |=>
		far_end_loopback_out == $past(regs.wdata[pbc_pkg::BC_LOOPBACK]))
		else $error("loopback does not follow the basic write");

	// speed written through control four shows on the output
	a_speed_alias: assert property (
		wm_ctrl4[pbc_pkg::C4_FORCE100] && !wm_basic[pbc_pkg::BC_FORCE100]
		|=> force_100_out == $past(regs.wdata[pbc_pkg::C4_FORCE100]))
		else $error("forced speed misses the control four write");

	// negotiation enable holds when neither location is written
	a_an_hold: assert property (
		!wm_basic[pbc_pkg::BC_AN_EN] && !wm_ctrl4[pbc_pkg::C4_AN_EN]
		|=> $stable(an_enable_out))
		else $error("negotiation enable changed without a write");

	// power-down written through control four reaches the output and view
	a_pdown_views: assert property (
		wm_ctrl4[pbc_pkg::C4_PDOWN] |=>
		power_down_out == $past(regs.wdata[pbc_pkg::C4_PDOWN]) &&
		view_basic[pbc_pkg::BC_PDOWN] == power_down_out)
		else $error("power-down views disagree");

	// unsupported and reserved read-only bits never read as one
	a_ro_zero: assert property (
		regs.rd_req && hit_basic |=> prdata_out[pbc_pkg::BC_ISOLATE] == 1'b0
		&& prdata_out[pbc_pkg::BC_COL_TEST] == 1'b0
		&& prdata_out[pbc_pkg::BC_RSVD6] == 1'b0
		&& prdata_out[pbc_pkg::BC_RSVD15] == 1'b0)
		else $error("read-only bit returned one");

	// a restart request stays up until the transceiver takes it
	a_restart_life: assert property (
		restart_set ##1 !an_restart_ack_in [*3] |-> an_restart_out)
		else $error("restart request dropped before it was taken");

	// an acknowledge with no new request clears the flag next cycle
	a_restart_clear: assert property (
		an_restart_out && an_restart_ack_in && !restart_set |=> !an_restart_out)
		else $error("restart flag did not clear after acknowledge");

	// duplex written by the basic register reads back through control four
	a_duplex_alias: assert property (
		wm_basic[pbc_pkg::BC_FULL_DUP] |=>
		view_ctrl4[pbc_pkg::C4_FULL_DUP] ==
		$past(regs.wdata[pbc_pkg::BC_FULL_DUP]))
		else $error("duplex alias not updated");

	// algorithm written through link status reaches the output
	a_xover_alias: assert property (
		wm_lstat[pbc_pkg::LS_XOVER_ALG] && !wm_basic[pbc_pkg::BC_XOVER_ALG]
		|=> crossover_algorithm_select_out ==
		$past(regs.wdata[pbc_pkg::LS_XOVER_ALG]))
		else $error("crossover algorithm misses the status write");

	// crossover and transmit bits written in basic read back in control four
	a_mdix_tx_views: assert property (
		wm_basic[pbc_pkg::BC_TX_DIS] |=>
		view_ctrl4[pbc_pkg::C4_FORCE_MDIX] ==
		$past(regs.wdata[pbc_pkg::BC_FORCE_MDIX])
		&& view_ctrl4[pbc_pkg::C4_MDIX_DIS] ==
		$past(regs.wdata[pbc_pkg::BC_MDIX_DIS])
		&& view_ctrl4[pbc_pkg::C4_TX_DIS] ==
		$past(regs.wdata[pbc_pkg::BC_TX_DIS]))
		else $error("crossover or transmit views disagree");

	// reserved bit 0 stores what was written
	a_rsvd_store: assert property (
		wm_basic[pbc_pkg::BC_RSVD0] ##1 !wm_basic[pbc_pkg::BC_RSVD0] |->
		view_basic[pbc_pkg::BC_RSVD0] == $past(regs.wdata[pbc_pkg::BC_RSVD0])
		) else $error("reserved bit 0 lost its value");
endmodule
`default_nettype wire

// ### verif/pbc_top_test.sv
// Purpose: self-checking bench for the port 1 basic control register bank
// Assumes: zero wait state APB slave, status inputs synced in 2-3 cycles
// Notes:   scenarios run in order and each starts from the state left before
`timescale 1ns/1ps
`default_nettype none
module pbc_top_test;
	logic        clk_sys_in;
	logic        reset_n_in;
	logic        psel_in;
	logic        penable_in;
	logic        pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in;
	logic [3:0]  pstrb_in;
	logic        pready_out;
	logic [31:0] prdata_out;
	logic        pslverr_out;
	logic        link_up_in;
	logic        an_done_in;
	logic        an_restart_ack_in;
	wire  [9:0]  ctl;
	logic [31:0] rd;
	logic        er;
	int          bad_count;
	int          comparisons;

	`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
		bad_count++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
		end end

	pbc_top u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
		.pready_out(pready_out), .prdata_out(prdata_out),
		.pslverr_out(pslverr_out), .link_up_in(link_up_in),
		.an_done_in(an_done_in), .an_restart_ack_in(an_restart_ack_in),
		.far_end_loopback_out(ctl[9]), .force_100_out(ctl[8]),
		.an_enable_out(ctl[7]), .power_down_out(ctl[6]),
		.an_restart_out(ctl[5]), .force_full_duplex_out(ctl[4]),
		.crossover_algorithm_select_out(ctl[3]), .force_mdix_out(ctl[2]),
		.auto_mdix_disable_out(ctl[1]), .tx_disable_out(ctl[0]));

	// free-running system clock, 10 ns period
	always #5 clk_sys_in = ~clk_sys_in;

	// one apb transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		pstrb_in   <= s;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("[ERR] %0t no pready", $time);
		end
		rd = prdata_out;
		er = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
	endtask

	// read a register and compare the whole word
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		`CHK(rd, e)
	endtask

	// reset values at the pins and in all three locations
	task automatic t_reset;
		`CHK(ctl, 10'h198)
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_3120);
		rd_chk(pbc_pkg::ADDR_CTRL4, 32'h0000_00e0);
		rd_chk(pbc_pkg::ADDR_LSTAT, 32'h0000_8000);
	endtask

	// byte strobes: low lane only, then no lane at all
	task automatic t_strobe;
		apb(1'b1, pbc_pkg::ADDR_BASIC, 32'h0000_ffff, 4'h1);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_313f);
		`CHK(ctl, 10'h19f)
		apb(1'b1, pbc_pkg::ADDR_BASIC, 32'h0000_0000, 4'h0);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_313f);
	endtask

	// every writable bit except the restart bit 9 set then cleared; read-only bits never stick
	task automatic t_all;
		apb(1'b1, pbc_pkg::ADDR_BASIC, 32'h0000_fdff, 4'h3);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_793f);
		`CHK(ctl, 10'h3df)
		rd_chk(pbc_pkg::ADDR_CTRL4, 32'h0000_5fe0);
		rd_chk(pbc_pkg::ADDR_LSTAT, 32'h0000_8000);
		// negotiation goes off together with forced duplex, as software should
		apb(1'b1, pbc_pkg::ADDR_BASIC, 32'h0000_0000, 4'h3);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_0000);
		`CHK(ctl, 10'h000)
		rd_chk(pbc_pkg::ADDR_CTRL4, 32'h0000_0000);
	endtask

	// writes through the alias locations show in the basic register
	task automatic t_alias;
		apb(1'b1, pbc_pkg::ADDR_CTRL4, 32'h0000_0100, 4'h3);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_4000);
		`CHK(ctl, 10'h200)
		apb(1'b1, pbc_pkg::ADDR_LSTAT, 32'h0000_8000, 4'h3);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_4020);
		apb(1'b1, pbc_pkg::ADDR_CTRL4, 32'h0000_0000, 4'h3);
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_0020);
	endtask

	// restart stays pending through a write of zero, clears on acknowledge
	task automatic t_restart;
		apb(1'b1, pbc_pkg::ADDR_BASIC, 32'h0000_0200, 4'h3);
		#1;
		`CHK(ctl[5], 1'b1)
		apb(1'b1, pbc_pkg::ADDR_BASIC, 32'h0000_0000, 4'h3);
		#1;
		`CHK(ctl[5], 1'b1)
		@(posedge clk_sys_in);
		an_restart_ack_in <= 1'b1;
		@(posedge clk_sys_in);
		an_restart_ack_in <= 1'b0;
		#1;
		`CHK(ctl[5], 1'b0)
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_0000);
	endtask

	// unmapped place answers with an error and leaves state alone
	task automatic t_err;
		apb(1'b1, 12'h200, 32'h0000_ffff, 4'h3);
		`CHK(er, 1'b1)
		apb(1'b0, 12'h200, 32'h0000_0000, 4'h0);
		`CHK(er, 1'b1)
		`CHK(rd, 32'h0000_0000)
		rd_chk(pbc_pkg::ADDR_BASIC, 32'h0000_0000);
		`CHK(er, 1'b0)
	endtask

	// synced transceiver status appears in the link status word
	task automatic t_status;
		@(posedge clk_sys_in);
		link_up_in <= 1'b1;
		an_done_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rd_chk(pbc_pkg::ADDR_LSTAT, 32'h0000_0060);
	endtask

	// the one place where the run ends
	task automatic give_verdict;
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// watchdog: the full run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		bad_count++;
		$display("[ERR] %0t watchdog expired", $time);
		give_verdict();
	end

	// main sequence
	initial begin
		clk_sys_in        = 1'b0;
		reset_n_in        = 1'b0;
		psel_in           = 1'b0;
		penable_in        = 1'b0;
		pwrite_in         = 1'b0;
		paddr_in          = 12'h000;
		pwdata_in         = 32'h0000_0000;
		pstrb_in          = 4'h0;
		link_up_in        = 1'b0;
		an_done_in        = 1'b0;
		an_restart_ack_in = 1'b0;
		bad_count         = 0;
		comparisons       = 0;
		repeat (20) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		@(posedge clk_sys_in);
		t_reset();
		t_strobe();
		t_all();
		t_alias();
		t_restart();
		t_err();
		t_status();
		give_verdict();
	end
endmodule
`default_nettype wire
